// file: axr_defs.vh
`ifndef AXR_DEFS_VH
`define AXR_DEFS_VH
// Register byte offsets.
`define AXR_OFF_ID 12'h0FC
`define AXR_OFF_CMD 12'h100
`define AXR_OFF_WFIFO 12'h104
`define AXR_OFF_ADDR 12'h108
`define AXR_OFF_DIV 12'h10C
`define AXR_OFF_OVF 12'h110
// Field positions.
`define AXR_CMD_LEN_MSB 3
`define AXR_CMD_LEN_LSB 0
`define AXR_CMD_CODE_MSB 11
`define AXR_CMD_CODE_LSB 8
`define AXR_CMD_AONLY_BIT 12
`define AXR_ADDR_MSB 19
`define AXR_DIV_MSB 7
`define AXR_FILT_MSB 15
`define AXR_FILT_LSB 8
`define AXR_OVF_BIT 0
// Command codes.
`define AXR_CODE_NAT_WR 4'h8
`define AXR_CODE_NAT_RD 4'h9
`define AXR_CODE_I2C_WR 4'h0
`define AXR_CODE_I2C_WR_MOT 4'h4
`define AXR_CODE_I2C_RD 4'h1
`define AXR_CODE_I2C_RD_MOT 4'h5
`define AXR_CODE_I2C_WR_STAT 4'h2
// Direction codes.
`define AXR_DIR_TX 8'h00
`define AXR_DIR_RX 8'h01
// Reset values.
`define AXR_RST_DIV 8'h7D
`define AXR_RST_FILT 8'h18
// Bus responses.
`define AXR_RESP_OKAY 2'h0
`define AXR_RESP_SLVERR 2'h2
`endif

// file: axr_aux_regs.v
`timescale 1ns/10ps
`include "axr_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Shift-style FIFO; the head always sits in entry 0 so the output is a flop.
module axr_fifo #(
    parameter WIDTH = 34,
    parameter DEPTH = 4
) (
    input wire mclk,
    input wire rst,
    input wire s_valid,
    output wire s_ready,
    input wire [WIDTH-1:0] s_data,
    output wire m_valid,
    input wire m_ready,
    output wire [WIDTH-1:0] m_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [DEPTH-1:0] vld_q;
    wire push;
    wire pop;
    assign s_ready = ~vld_q[DEPTH-1];
    assign m_valid = vld_q[0];
    assign m_data = mem_q[0];
    assign push = s_valid & s_ready;
    assign pop = vld_q[0] & m_ready;
    genvar i;
    generate
        for (i = 0; i < DEPTH; i = i + 1) begin : g_ent
            wire nxt_vld;
            wire [WIDTH-1:0] nxt_mem;
            wire prev_vld;
            if (i == DEPTH - 1) begin : g_last
                assign nxt_vld = 1'b0;
                assign nxt_mem = {WIDTH{1'b0}};
            end else begin : g_mid
                assign nxt_vld = vld_q[i+1];
                assign nxt_mem = mem_q[i+1];
            end
            if (i == 0) begin : g_first
                assign prev_vld = 1'b1;
            end else begin : g_rest
                assign prev_vld = vld_q[i-1];
            end
            always @(posedge mclk or posedge rst) begin
                if (rst) begin
                    vld_q[i] <= 1'b0;
                    mem_q[i] <= {WIDTH{1'b0}};
                end else if (pop) begin
                    if (push && vld_q[i] && !nxt_vld) begin
                        vld_q[i] <= 1'b1;
                        mem_q[i] <= s_data;
                    end else begin
                        vld_q[i] <= nxt_vld;
                        mem_q[i] <= nxt_mem;
                    end
                end else if (push && !vld_q[i] && prev_vld) begin
                    vld_q[i] <= 1'b1;
                    mem_q[i] <= s_data;
                end
            end
        end
    endgenerate
endmodule // axr_fifo

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Identification low byte reads 0x00 for transmit, 0x01 for receive.
// - Identification upper bytes report protocol major, minor and revision.
// - Writing the command register launches a request with its type and length.
// - Length field holds byte count minus one, giving 1 to 16 bytes.
// - Command bit 12 requests an address-only transfer, no data phase.
// - Command bits 11:8 select native or I2C read, write, MOT, status.
// - Payload FIFO takes one byte per write from bits 7:0, up to 16.
// - The 20-bit address register gives the burst start address.
// - A 1 MHz tick comes from dividing the host clock by the divider.
// - Divider bits 15:8 set filter width; only 8 to 48 by 8.
// - Video FIFO overflow is flagged in a clear-on-read status register.
// - Overflow is raised when video rate mismatches the transfer unit size.
// - Overflow status bit 0 reads 1 after overflow, 0 after a read taken with no new overflow in its cycle.
module axr_aux_regs #(
    parameter IS_RECEIVER = 0,
    parameter [7:0] PROTO_MAJOR = 8'h02,
    parameter [7:0] PROTO_MINOR = 8'h03,
    parameter [7:0] PROTO_REV = 8'h04,
    parameter FIFO_DEPTH = 4
) (
    input wire mclk,
    input wire rst,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire transfer_unit_overflow,
    output wire req_start,
    output wire [3:0] req_code,
    output wire [4:0] req_bytes,
    output wire req_addr_only,
    output wire req_is_read,
    output wire [19:0] req_address,
    output wire pay_valid,
    input wire pay_ready,
    output wire [33:0] pay_data,
    output wire tick_1us,
    output wire [7:0] filter_width
);
    localparam FW = 34;
    reg awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    reg [1:0] bresp_q, rresp_q;
    reg [31:0] rdata_q;
    reg [12:0] cmd_q;
    reg [19:0] addr_q;
    reg [7:0] div_q, filt_q, tick_cnt_q;
    reg ovf_q, start_q, is_read_q, tick_q;
    reg [4:0] bytes_q;
    reg [31:0] pack_q;
    reg [1:0] pack_cnt_q;
    wire [11:0] wa = {s_axi_awaddr[11:2], 2'b00};
    wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
    wire ff_s_ready;
    wire fifo_user = (wa == `AXR_OFF_WFIFO) || (wa == `AXR_OFF_CMD);
    // A full payload FIFO holds off the write handshake instead of dropping data.
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q && !awready_q
        && !(fifo_user && !ff_s_ready);
    wire rd_go = s_axi_arvalid && !rvalid_q && !arready_q;
    wire wr_byte = wr_go && (wa == `AXR_OFF_WFIFO) && s_axi_wstrb[0];
    wire wr_cmd = wr_go && (wa == `AXR_OFF_CMD);
    wire [31:0] pack_next = pack_q | ({24'h000000, s_axi_wdata[7:0]} << {pack_cnt_q, 3'b000});
    reg push;
    reg [FW-1:0] push_data;
    wire [31:0] bmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire [31:0] cmd_w = ({19'h00000, cmd_q} & ~bmask) | (s_axi_wdata & bmask);
    wire [31:0] addr_w = ({12'h000, addr_q} & ~bmask) | (s_axi_wdata & bmask);
    wire [7:0] filt_w = s_axi_wstrb[1] ? s_axi_wdata[`AXR_FILT_MSB:`AXR_FILT_LSB] : filt_q;
    wire filt_ok = (filt_w[2:0] == 3'h0) && (filt_w != 8'h00) && (filt_w <= 8'h30);
    wire [3:0] code_w = cmd_w[`AXR_CMD_CODE_MSB:`AXR_CMD_CODE_LSB];
    wire [7:0] dir_code = (IS_RECEIVER != 0) ? `AXR_DIR_RX : `AXR_DIR_TX;

    ////////////////////////////////////////////////////////////////////////////
    // Bytes are packed four to a FIFO word; a command write flushes a partial
    // word. Word bits 33:32 hold the count of valid bytes minus one.
    always @* begin
        push = 1'b0;
        push_data = {pack_cnt_q, pack_next};
        if (wr_byte && pack_cnt_q == 2'h3) begin
            push = 1'b1;
        end else if (wr_cmd && pack_cnt_q != 2'h0) begin
            push = 1'b1;
            push_data = {pack_cnt_q - 2'h1, pack_q};
        end
    end

    axr_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .s_valid(push),
        .s_ready(ff_s_ready),
        .s_data(push_data),
        .m_valid(pay_valid),
        .m_ready(pay_ready),
        .m_data(pay_data)
    );

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            pack_q <= 32'h00000000;
            pack_cnt_q <= 2'h0;
        end else if (push || wr_cmd) begin
            pack_q <= 32'h00000000;
            pack_cnt_q <= 2'h0;
        end else if (wr_byte) begin
            pack_q <= pack_next;
            pack_cnt_q <= pack_cnt_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channel and writable registers.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `AXR_RESP_OKAY;
            cmd_q <= 13'h0000;
            addr_q <= 20'h00000;
            div_q <= `AXR_RST_DIV;
            filt_q <= `AXR_RST_FILT;
            start_q <= 1'b0;
            is_read_q <= 1'b0;
            bytes_q <= 5'h01;
        end else begin
            awready_q <= wr_go;
            wready_q <= wr_go;
            start_q <= wr_cmd;
            if (s_axi_bready && bvalid_q) begin
                bvalid_q <= 1'b0;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= `AXR_RESP_OKAY;
                case (wa)
                    `AXR_OFF_CMD: begin
                        cmd_q <= cmd_w[12:0];
                        // Registered so the byte count output comes straight from a flop.
                        bytes_q <= {1'b0, cmd_w[`AXR_CMD_LEN_MSB:`AXR_CMD_LEN_LSB]} + 5'h01;
                        is_read_q <= (code_w == `AXR_CODE_NAT_RD)
                            || (code_w == `AXR_CODE_I2C_RD)
                            || (code_w == `AXR_CODE_I2C_RD_MOT);
                    end
                    `AXR_OFF_ADDR: begin
                        addr_q <= addr_w[`AXR_ADDR_MSB:0];
                    end
                    `AXR_OFF_DIV: begin
                        if (s_axi_wstrb[0]) begin
                            div_q <= s_axi_wdata[`AXR_DIV_MSB:0];
                        end
                        // Disallowed widths are ignored so the filter stays sane.
                        if (filt_ok) begin
                            filt_q <= filt_w;
                        end
                    end
                    `AXR_OFF_WFIFO, `AXR_OFF_ID, `AXR_OFF_OVF: begin
                        bresp_q <= `AXR_RESP_OKAY;
                    end
                    default: begin
                        bresp_q <= `AXR_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel; reading the overflow register clears the flag.
    wire rd_ovf = rd_go && (ra == `AXR_OFF_OVF);
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `AXR_RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            arready_q <= rd_go;
            if (s_axi_rready && rvalid_q) begin
                rvalid_q <= 1'b0;
            end
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rresp_q <= `AXR_RESP_OKAY;
                rdata_q <= 32'h00000000;
                case (ra)
                    `AXR_OFF_ID: begin
                        rdata_q <= {PROTO_MAJOR, PROTO_MINOR, PROTO_REV, dir_code};
                    end
                    `AXR_OFF_CMD: begin
                        rdata_q <= {19'h00000, cmd_q};
                    end
                    `AXR_OFF_WFIFO: begin
                        rdata_q <= 32'h00000000;
                    end
                    `AXR_OFF_ADDR: begin
                        rdata_q <= {12'h000, addr_q};
                    end
                    `AXR_OFF_DIV: begin
                        rdata_q <= {16'h0000, filt_q, div_q};
                    end
                    `AXR_OFF_OVF: begin
                        rdata_q <= {31'h00000000, ovf_q};
                    end
                    default: begin
                        rresp_q <= `AXR_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag: a new event in the clearing read's cycle stays set.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else if (transfer_unit_overflow) begin
            ovf_q <= 1'b1;
        end else if (rd_ovf) begin
            ovf_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timebase: divider 0 behaves as 1 so the tick never stops.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else if (tick_cnt_q + 8'h01 >= div_q) begin
            tick_cnt_q <= 8'h00;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
            tick_q <= 1'b0;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign req_start = start_q;
    assign req_code = cmd_q[`AXR_CMD_CODE_MSB:`AXR_CMD_CODE_LSB];
    assign req_bytes = bytes_q;
    assign req_addr_only = cmd_q[`AXR_CMD_AONLY_BIT];
    assign req_is_read = is_read_q;
    assign req_address = addr_q;
    assign tick_1us = tick_q;
    assign filter_width = filt_q;
endmodule // axr_aux_regs

// file: axr_aux_sink_model.sv
`timescale 1ns/10ps
// Far side of the request path: pops payload words, slowly (every other cycle) unless stalled.
module axr_aux_sink_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic stall,
    input wire logic pay_valid,
    input wire logic [33:0] pay_data,
    output logic pay_ready
);
    logic [33:0] words [0:31];
    logic ph_q;
    int n;
    assign pay_ready = !stall && ph_q;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            ph_q <= 1'b0;
            n <= 0;
        end else begin
            ph_q <= ~ph_q;
            if (pay_valid && pay_ready) begin
                words[n[4:0]] <= pay_data;
                n <= n + 1;
            end
        end
    end
endmodule // axr_aux_sink_model

// file: axr_aux_regs_checker.sv
`timescale 1ns/10ps
module axr_aux_regs_checker #(
    parameter [7:0] PROTO_MAJOR = 8'h02,
    parameter [7:0] PROTO_MINOR = 8'h03,
    parameter [7:0] PROTO_REV = 8'h04
) (
    input wire mclk,
    input wire rst,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire req_start,
    input wire [3:0] req_code,
    input wire [4:0] req_bytes,
    input wire pay_valid,
    input wire pay_ready,
    input wire [33:0] pay_data,
    input wire tick_1us,
    input wire [7:0] filter_width
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    // Writes to the payload and command offsets may stall on a full FIFO, so they are left out.
    write_take_a: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
        && s_axi_awaddr[11:3] != 9'h020 |=> s_axi_awready && s_axi_bvalid) else $error("write not taken");
    ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready too long");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_take_a: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
        |=> s_axi_arready && s_axi_rvalid) else $error("read not taken");
    id_value_a: assert property (s_axi_arready && s_axi_araddr == 12'h0FC
        |-> s_axi_rdata == {PROTO_MAJOR, PROTO_MINOR, PROTO_REV, 8'h00}) else $error("bad id");
    cmd_start_a: assert property (s_axi_awready && s_axi_awaddr == 12'h100 |-> req_start)
        else $error("no start");
    start_fields_a: assert property (req_start |-> s_axi_awready && s_axi_awaddr == 12'h100
        && req_code == s_axi_wdata[11:8] && req_bytes == s_axi_wdata[3:0] + 5'h01) else $error("bad start");
    filter_legal_a: assert property (filter_width[2:0] == 3'h0 && filter_width >= 8'h08
        && filter_width <= 8'h30) else $error("illegal filter width");
    tick_pulse_a: assert property (tick_1us |=> !tick_1us) else $error("tick too long");
    pay_hold_a: assert property (pay_valid && !pay_ready |=> pay_valid && $stable(pay_data))
        else $error("payload changed while stalled");
    cover property (req_start);
    cover property (pay_valid && pay_ready);
    cover property (tick_1us);
endmodule // axr_aux_regs_checker
bind axr_aux_regs axr_aux_regs_checker #(.PROTO_MAJOR(PROTO_MAJOR), .PROTO_MINOR(PROTO_MINOR),
    .PROTO_REV(PROTO_REV)) u_axr_aux_regs_checker (.*);

// file: test_axr_aux_regs.sv
`timescale 1ns/10ps
module test_axr_aux_regs;
    logic mclk = 0, rst = 1, awvalid = 0, wvalid = 0, arvalid = 0, ovf = 0, stall = 1;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd_q;
    logic [1:0] resp_q;
    logic [3:0] strb = 4'hF;
    logic [3:0] codes [0:6] = '{4'h8, 4'h9, 4'h0, 4'h4, 4'h1, 4'h5, 4'h2};
    wire awready, wready, bvalid, arready, rvalid, req_start, req_addr_only, req_is_read;
    wire pay_valid, pay_ready, tick;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] req_code;
    wire [4:0] req_bytes;
    wire [19:0] req_address;
    wire [33:0] pay_data;
    wire [7:0] filter_width;
    int mismatches = 0, num_checks = 0, waited, base, gap;
    always #4 mclk = ~mclk;
    axr_aux_regs u_axr_aux_regs (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .transfer_unit_overflow(ovf), .req_start(req_start),
        .req_code(req_code), .req_bytes(req_bytes), .req_addr_only(req_addr_only),
        .req_is_read(req_is_read), .req_address(req_address), .pay_valid(pay_valid),
        .pay_ready(pay_ready), .pay_data(pay_data), .tick_1us(tick), .filter_width(filter_width));
    axr_aux_sink_model u_axr_aux_sink_model (.mclk(mclk), .rst(rst), .stall(stall),
        .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request is held until the edge at which its ready is seen high.
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        #1 {awaddr, wdata, awvalid, wvalid} = {a, d, 2'b11};
        waited = 0;
        while (awready !== 1'b1 && waited < 400) begin
            @(negedge mclk);
            waited++;
        end
        resp_q = bresp;
        chk("wready", 1, wready);
        @(posedge mclk);
        #1 {awvalid, wvalid} = 2'b00;
        if (waited >= 400) chk("awready", 1, 0);
    endtask
    task rd(input logic [11:0] a);
        @(posedge mclk);
        #1 {araddr, arvalid} = {a, 1'b1};
        waited = 0;
        while (arready !== 1'b1 && waited < 400) begin
            @(negedge mclk);
            waited++;
        end
        rd_q = rdata;
        resp_q = rresp;
        @(posedge mclk);
        #1 arvalid = 0;
        if (waited >= 400) chk("arready", 1, 0);
    endtask
    task tick_gap;
        gap = 0;
        do begin
            @(negedge mclk);
            gap++;
        end while (tick !== 1'b1 && gap < 300);
        gap = 0;
        do begin
            @(negedge mclk);
            gap++;
        end while (tick !== 1'b1 && gap < 300);
    endtask
    task wrap_up;
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge mclk);
        #1 rst = 0;
        rd(12'h0FC); chk("id", 32'h02030400, rd_q);
        rd(12'h10C); chk("divider reset", 32'h0000187D, rd_q);
        wr(12'h0FC, 32'hFFFFFFFF); chk("id write resp", 2'h0, resp_q);
        rd(12'h0FC); chk("id kept", 32'h02030400, rd_q);
        wr(12'h200, 32'h1); chk("unmapped resp", 2'h2, resp_q);
        rd(12'h200); chk("unmapped read resp", 2'h2, resp_q);
        rd(12'h104); chk("payload reads zero", 0, rd_q);
        wr(12'h108, 32'h000ABCDE); chk("address", 20'hABCDE, req_address);
        for (int i = 0; i < 5; i++) wr(12'h104, 32'h11 * (i + 1));
        base = u_axr_aux_sink_model.n;
        wr(12'h100, 32'h00000804);
        chk("code", 4'h8, req_code);
        chk("bytes", 5'd5, req_bytes);
        chk("is_read", 0, req_is_read);
        chk("addr_only", 0, req_addr_only);
        stall = 0;
        repeat (20) @(posedge mclk);
        chk("popped", base + 2, u_axr_aux_sink_model.n);
        chk("word0", {2'h3, 32'h44332211}, u_axr_aux_sink_model.words[base]);
        chk("word1", 10'h055, {u_axr_aux_sink_model.words[base + 1][33:32],
            u_axr_aux_sink_model.words[base + 1][7:0]});
        for (int i = 0; i < 7; i++) begin
            wr(12'h100, 32'h0000000F | (codes[i] << 8) | ((i % 2) << 12));
            chk("code", codes[i], req_code);
            chk("bytes", 5'd16, req_bytes);
            chk("is_read", codes[i] == 4'h9 || codes[i] == 4'h1 || codes[i] == 4'h5, req_is_read);
            chk("addr_only", i % 2, req_addr_only);
        end
        stall = 1;
        base = u_axr_aux_sink_model.n;
        for (int i = 0; i < 16; i++) wr(12'h104, i);
        fork
            wr(12'h104, 32'hAA);
            begin
                repeat (12) @(posedge mclk);
                #1 stall = 0;
            end
        join
        chk("full stall", 1, waited >= 12);
        wr(12'h100, 32'h00000800);
        repeat (40) @(posedge mclk);
        chk("popped", base + 5, u_axr_aux_sink_model.n);
        chk("word3", {2'h3, 32'h0F0E0D0C}, u_axr_aux_sink_model.words[base + 3]);
        chk("word4", 10'h0AA, {u_axr_aux_sink_model.words[base + 4][33:32],
            u_axr_aux_sink_model.words[base + 4][7:0]});
        wr(12'h10C, 32'h00003004); chk("filter", 8'h30, filter_width);
        wr(12'h10C, 32'h00001304); chk("filter kept", 8'h30, filter_width);
        strb = 4'h2;
        wr(12'h10C, 32'h00000810); chk("filter strobe", 8'h08, filter_width);
        strb = 4'hF;
        tick_gap; tick_gap; chk("tick gap", 4, gap);
        wr(12'h10C, 32'h0000307D);
        tick_gap; tick_gap; chk("tick gap", 125, gap);
        @(posedge mclk);
        #1 ovf = 1;
        // The event is still present at the clearing read, so the flag must survive it.
        rd(12'h110); chk("overflow set", 1, rd_q);
        ovf = 0;
        rd(12'h110); chk("overflow kept", 1, rd_q);
        rd(12'h110); chk("overflow clear", 0, rd_q);
        wrap_up;
    end
    initial begin
        #100000;
        mismatches++;
        wrap_up;
    end
endmodule // test_axr_aux_regs
